// file: rtl/pcs_pkg.sv
`default_nettype none
package pcs_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int OFF_TIMEOUT_US = 500;
  localparam int LATCH_TIMEOUT_US = 500;
  localparam int MAX_PULSE_HZ = 1000000;
  localparam int OFF_CYCLES = OFF_TIMEOUT_US * (CLK_HZ / 1000000);
  localparam int LATCH_CYCLES = LATCH_TIMEOUT_US * (CLK_HZ / 1000000);
  localparam int TMR_W = 16;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NSW_MAX = 6;
  localparam int NSW_SMALL = 3;
  localparam logic [NSW_MAX-1:0] ALL_ON = 6'h3F;
  localparam logic [NSW_MAX-1:0] ALL_OFF = 6'h00;
  localparam logic [NSW_MAX-1:0] CNT_FIRST = 6'h00;

  typedef enum logic [1:0] {
    PCS_OFF = 2'b00,
    PCS_LOW = 2'b01,
    PCS_HIGH = 2'b10,
    PCS_HELD = 2'b11
  } pcs_state_e;

  typedef struct packed {
    logic enabled;
    logic [NSW_MAX-1:0] sw_on;
  } pcs_out_s;
endpackage
`default_nettype wire

// file: rtl/pcs_sync.sv
`default_nettype none
module pcs_sync (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  logic sync_ff;
  // ---------------------------------------------------------------
  // Two-stage synchroniser; first stage feeds only the second
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule
`default_nettype wire

// file: rtl/pcs_ctrl.sv
`default_nettype none
module pcs_ctrl #(
  parameter int NSW = pcs_pkg::NSW_MAX,
  parameter int OFF_CYC = pcs_pkg::OFF_CYCLES,
  parameter int LAT_CYC = pcs_pkg::LATCH_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ctrl_in,
  output pcs_pkg::pcs_out_s status,
  output logic [NSW-1:0] switch_on
);
  import pcs_pkg::*;

  // ---------------------------------------------------------------
  // Input sampling
  // ---------------------------------------------------------------
  logic line;
  logic line_d_ff;
  pcs_sync u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .din(ctrl_in),
    .dout(line)
  );
  wire rise = line & ~line_d_ff;

  function automatic logic [NSW-1:0] decode(input logic [NSW-1:0] cnt);
    decode = ~cnt;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pcs_state_e state_ff, nxt_state;
  logic [NSW-1:0] cnt_ff, nxt_cnt;
  logic [TMR_W-1:0] tmr_ff, nxt_tmr;
  logic [NSW-1:0] sw_ff, nxt_sw;
  logic en_ff, nxt_en;

  // Counter width equals NSW, so the three-switch build wraps at 8 for free
  wire [NSW-1:0] cnt_inc = cnt_ff + {{(NSW-1){1'b0}}, 1'b1};
  wire lat_done = (tmr_ff == TMR_W'(LAT_CYC - 1));
  wire off_done = (tmr_ff == TMR_W'(OFF_CYC - 1));
  wire [TMR_W-1:0] tmr_inc = tmr_ff + {{(TMR_W-1){1'b0}}, 1'b1};

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_tmr = tmr_ff;
    nxt_sw = sw_ff;
    nxt_en = en_ff;
    case (state_ff)
      PCS_OFF: begin
        nxt_tmr = '0;
        if (rise) begin
          nxt_state = PCS_HIGH;
          nxt_cnt = NSW'(CNT_FIRST);
          nxt_sw = NSW'(ALL_ON);
          nxt_en = 1'b1;
        end
      end
      PCS_LOW: begin
        nxt_tmr = tmr_inc;
        if (rise) begin
          nxt_state = PCS_HIGH;
          nxt_cnt = cnt_inc;
          nxt_tmr = '0;
        end else if (off_done) begin
          nxt_state = PCS_OFF;
          nxt_cnt = NSW'(CNT_FIRST);
          nxt_sw = NSW'(ALL_OFF);
          nxt_en = 1'b0;
          nxt_tmr = '0;
        end
      end
      PCS_HIGH: begin
        nxt_tmr = tmr_inc;
        if (!line) begin
          nxt_state = PCS_LOW;
          nxt_tmr = '0;
        end else if (lat_done) begin
          nxt_state = PCS_HELD;
          nxt_sw = decode(cnt_ff);
          nxt_tmr = '0;
        end
      end
      PCS_HELD: begin
        nxt_tmr = '0;
        // Later pulses keep counting; pattern only moves after a new latch or at the off timeout
        if (!line) begin
          nxt_state = PCS_LOW;
        end
      end
      default: begin
        nxt_state = PCS_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_ff <= PCS_OFF;
      cnt_ff <= '0;
      tmr_ff <= '0;
      sw_ff <= '0;
      en_ff <= 1'b0;
      line_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      tmr_ff <= nxt_tmr;
      sw_ff <= nxt_sw;
      en_ff <= nxt_en;
      line_d_ff <= line;
    end
  end

  assign switch_on = sw_ff;
  assign status = '{enabled: en_ff, sw_on: NSW_MAX'(sw_ff)};

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_low_long;
    (state_ff == PCS_LOW) && off_done && !rise;
  endsequence

  property p_count_rise;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_LOW && rise) |=> (cnt_ff == $past(cnt_ff) + 1'b1);
  endproperty
  a_count_rise: assert property (p_count_rise) else $error("no count on rise");

  property p_no_count_fall;
    @(posedge core_clk) disable iff (!rstn)
      (!rise && state_ff != PCS_LOW) |=> $stable(cnt_ff) || state_ff == PCS_OFF;
  endproperty
  a_no_count_fall: assert property (p_no_count_fall) else $error("count without rise");

  property p_latch;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_HIGH && line && lat_done) |=> (sw_ff == ~$past(cnt_ff));
  endproperty
  a_latch: assert property (p_latch) else $error("latch pattern wrong");

  property p_no_early_latch;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_HIGH && !lat_done) |=> $stable(sw_ff);
  endproperty
  a_no_early_latch: assert property (p_no_early_latch) else $error("early latch");

  property p_first_on;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_OFF && rise) |=> (sw_ff == {NSW{1'b1}}) && en_ff && cnt_ff == '0;
  endproperty
  a_first_on: assert property (p_first_on) else $error("first edge not all on");

  property p_off;
    @(posedge core_clk) disable iff (!rstn)
      s_low_long |=> (sw_ff == '0) && !en_ff;
  endproperty
  a_off: assert property (p_off) else $error("off timeout missed");

  property p_clear;
    @(posedge core_clk) disable iff (!rstn)
      s_low_long |=> (cnt_ff == '0) && (state_ff == PCS_OFF);
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared");

  property p_fast_low;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_HIGH && !line) |=> (state_ff == PCS_LOW) && en_ff;
  endproperty
  a_fast_low: assert property (p_fast_low) else $error("short low lost");

  property p_all_off_max;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_HIGH && lat_done && line && cnt_ff == {NSW{1'b1}}) |=> sw_ff == '0;
  endproperty
  a_all_off_max: assert property (p_all_off_max) else $error("last count not all off");

  property p_wrap;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_LOW && rise && cnt_ff == {NSW{1'b1}}) |=> cnt_ff == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  property p_decode_space;
    @(posedge core_clk) disable iff (!rstn)
      state_ff == PCS_HELD |-> (sw_ff == ~cnt_ff) && en_ff;
  endproperty
  a_decode_space: assert property (p_decode_space) else $error("held pattern wrong");

  property p_held_keep;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_HELD && line) |=> $stable(sw_ff) && en_ff;
  endproperty
  a_held_keep: assert property (p_held_keep) else $error("held pattern moved");

  property p_off_state;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_OFF) |-> (sw_ff == '0) && !en_ff;
  endproperty
  a_off_state: assert property (p_off_state) else $error("switch on while off");

  property p_no_early_off;
    @(posedge core_clk) disable iff (!rstn)
      (state_ff == PCS_LOW && !rise && !off_done) |=> (state_ff == PCS_LOW) && en_ff;
  endproperty
  a_no_early_off: assert property (p_no_early_off) else $error("early disable");
endmodule
`default_nettype wire

// file: tb/pcs_host.sv
`default_nettype none
module pcs_host (
  input wire logic core_clk,
  output var logic ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Host output pin
  // ------------------------------------------------------------
  initial ctrl = 1'b0;
  // One low gap then one rise; callers keep gaps far below the off timeout
  task automatic pulse(input int lo, input int hi);
    @(posedge core_clk) ctrl <= 1'b0;
    repeat (lo) @(posedge core_clk);
    ctrl <= 1'b1;
    repeat (hi) @(posedge core_clk);
  endtask
  // Line stays high while the setting must stand
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic off(input int n);
    @(posedge core_clk) ctrl <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcs_pkg::*;
  // ------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------
  localparam int CYC = 50;
  logic core_clk;
  logic rstn;
  logic ctrl_in;
  pcs_out_s status;
  pcs_out_s last;
  pcs_out_s e;
  pcs_out_s exp_q[$];
  logic [5:0] sw6;
  logic [2:0] sw3;
  int n_errors;
  int tests_run;
  int seed;
  int cnt;
  int k;
  pcs_host host (.core_clk(core_clk), .ctrl(ctrl_in));
  pcs_ctrl #(.NSW(6), .OFF_CYC(CYC), .LAT_CYC(CYC)) dut (.core_clk(core_clk), .rstn(rstn),
    .ctrl_in(ctrl_in), .status(status), .switch_on(sw6));
  pcs_ctrl #(.NSW(3), .OFF_CYC(CYC), .LAT_CYC(CYC)) dut3 (.core_clk(core_clk), .rstn(rstn),
    .ctrl_in(ctrl_in), .status(), .switch_on(sw3));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic note(input logic en, input logic [5:0] pat);
    exp_q.push_back({en, pat});
  endtask
  // Widths of 10 cycles or more keep the rate at or under 1 MHz
  task automatic send(input int n);
    repeat (n) host.pulse(10 + ($random(seed) & 3), 10 + ($random(seed) & 3));
    host.hold(CYC + 20);
  endtask
  // Compare only on a change, so a latch that keeps the pattern needs no note
  always @(negedge core_clk) begin
    if (rstn === 1'b1 && status !== last) begin
      tests_run++;
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("mismatch status expected none seen %h", status);
      end else begin
        e = exp_q.pop_front();
        if (status !== e || sw6 !== e.sw_on || sw3 !== e.sw_on[2:0]) begin
          n_errors++;
          $display("mismatch status expected %h seen %h small %h", e, status, sw3);
        end
      end
    end
    last = status;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    stop_test();
  end
  initial begin
    n_errors = 0;
    tests_run = 0;
    seed = 32'h9e3dbd36;
    cnt = 0;
    last = '0;
    rstn = 1'b0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    note(1'b1, ALL_ON);
    send(1);
    for (int i = 0; i < 6; i++) begin
      k = 1 + ($random(seed) & 31);
      cnt = (cnt + k) % 64;
      note(1'b1, ~6'(cnt));
      send(k);
    end
    for (int i = 0; i < 3; i++) begin
      cnt = (cnt + 1) % 64;
      note(1'b1, ~6'(cnt));
      send(1);
    end
    note(1'b0, ALL_OFF);
    host.off(CYC + 20);
    note(1'b1, ALL_ON);
    note(1'b1, 6'h37);
    send(9);
    note(1'b1, ALL_OFF);
    send(55);
    note(1'b0, ALL_OFF);
    host.off(CYC + 20);
    tests_run++;
    if (exp_q.size() != 0) begin
      n_errors++;
      $display("mismatch pending expected 0 seen %0d", exp_q.size());
    end
    stop_test();
  end
endmodule
`default_nettype wire
